// File: rtl/fsl_pkg.sv
// Constants shared by the fieldbus status indicator encoder
package fsl_pkg;

	// Clock and the one shared blink time base
	localparam int CLK_HZ       = 25_000_000;
	localparam int TICK_US      = 500;
	localparam int TICK_CYC     = CLK_HZ / 1_000_000 * TICK_US;
	localparam int TICK_HZ      = 1_000_000 / TICK_US;

	// Blink rates in millihertz, and the loop phase length in ms
	localparam int F_INIT_MHZ   = 12_500;
	localparam int F_RECOV_MHZ  = 4_000;
	localparam int F_CFG_MHZ    = 660;
	localparam int F_FATAL_MHZ  = 8_000;
	localparam int F_FB_MHZ     = 4_000;
	localparam int FB_HALF_MS   = 125;

	// Half periods counted in ticks; frequency forms round down
	localparam int HALF_INIT    = TICK_HZ * 1000 / (2 * F_INIT_MHZ);
	localparam int HALF_RECOV   = TICK_HZ * 1000 / (2 * F_RECOV_MHZ);
	localparam int HALF_CFG     = TICK_HZ * 1000 / (2 * F_CFG_MHZ);
	localparam int HALF_FATAL   = TICK_HZ * 1000 / (2 * F_FATAL_MHZ);
	localparam int HALF_FB      = FB_HALF_MS * 1000 / TICK_US;

	// Red blinks shown after power-up
	localparam int PWRUP_BLINKS = 3;

	// Communication phases
	localparam logic [2:0] CP2  = 3'h2;
	localparam logic [2:0] CP3  = 3'h3;
	localparam logic [2:0] CP4  = 3'h4;

	// Register map (byte addresses) and field positions
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam int CTRL_ACK     = 0;
	localparam int CTRL_IDENT   = 1;
	localparam int CTRL_MSGCLR  = 2;
	localparam int ST_PWR       = 0;
	localparam int ST_SGRN      = 1;
	localparam int ST_SRED      = 2;
	localparam int ST_FGRN      = 3;
	localparam int ST_FRED      = 4;
	localparam int ST_DIAG      = 5;
	localparam int ST_COMM      = 6;
	localparam int ST_MSG       = 7;
	localparam int ST_PREV      = 8;
	localparam int ST_PUDONE    = 9;
	localparam int ST_LOOP      = 10;
	localparam int ST_PHASE     = 12;
	localparam logic [31:0] RD_IDLE = 32'h0000_0000;

	// Power-up sequence
	typedef enum logic {
		PU_SHOW = 1'b0,
		PU_RUN  = 1'b1
	} fsl_pu_t;

endpackage

// File: rtl/fsl_sync.sv
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module fsl_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk, // System clock
	input  wire logic         rst_n,   // Async reset, active low
	input  wire logic [W-1:0] din,     // Asynchronous levels
	output logic      [W-1:0] dout     // Synchronised levels
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			dout   <= '0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end

endmodule

// File: rtl/fsl_blink.sv
// Square wave from the shared tick, equal on and off time
`timescale 1ns/1ps
module fsl_blink #(
	parameter int HALF = 80
) (
	input  wire logic ref_clk, // System clock
	input  wire logic rst_n,   // Async reset, active low
	input  wire logic tick,    // One-cycle time base pulse
	output logic      wave     // Blink phase, high = lit
);

	localparam int CW = $clog2(HALF + 1);
	localparam logic [CW-1:0] LAST = CW'(HALF - 1);

	logic [CW-1:0] cnt_q;

	// Count ticks, flip the phase each half period
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			wave  <= 1'b0;
		end else if (tick) begin
			if (cnt_q == LAST) begin
				cnt_q <= '0;
				wave  <= ~wave;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

endmodule

// File: rtl/fsl_led_top.sv
// Status indicator encoder for the fieldbus interface
//
// How it works
// - Power-good indicator lit steadily while supply present, dark otherwise.
// - Status indicator dark when supply absent or interface inoperable.
// - Status indicator steady green when ready and error free.
// - Status indicator blinks green at 12.5 Hz during initialisation.
// - Recoverable error blinks status green at 4 Hz until removed.
// - Unsaved configuration blinks status green at 0.66 Hz.
// - Unrecoverable error blinks status red at 8 Hz.
// - Several red power-up blinks mark initialisation, not an error.
// - Failed firmware update restarts on the previous firmware image.
// - Fieldbus indicator dark without power or with a broken link.
// - Fieldbus steady green in phase CP4 with no error.
// - Loopback blinks fieldbus green at 4 Hz, 125 ms phases.
// - In loopback each telegram returns on its arrival port.
// - Fieldbus steady red on port 1 diagnostic error or lost communication.
// - Error indications clear on acknowledge when cleared, or CP2 to CP3.
// - Acknowledge leaves other pending diagnostic messages outstanding.
// - Communication error alternates fieldbus red and green at 4 Hz.
// - Fieldbus steady orange in CP0 to CP3 while receiving telegrams.
// - Identification request blinks fieldbus orange at 4 Hz.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module fsl_led_top
	import fsl_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC,
	parameter int PU_BLINKS   = PWRUP_BLINKS
) (
	input  wire logic        ref_clk,       // 25 MHz system clock
	input  wire logic        rst_n,         // Async reset, active low
	input  wire logic        supplyOk,      // Supply present
	input  wire logic        ifOperable,    // Interface alive
	input  wire logic        ifReady,       // Initialised and ready
	input  wire logic        ifInit,        // Initialisation phase
	input  wire logic        errRecov,      // Recoverable error
	input  wire logic        cfgUnsaved,    // Config not in flash
	input  wire logic        errFatal,      // Unrecoverable error
	input  wire logic        linkUp,        // Connection present
	input  wire logic        loopback,      // Ring broken, looping
	input  wire logic        diagErrP1,     // Diag class error port 1
	input  wire logic        commLost,      // Ports cannot talk
	input  wire logic        commErr,       // Bad telegram or CRC
	input  wire logic        rxTelegram,    // Telegrams arriving
	input  wire logic        diagMsg,       // Other diag message
	input  wire logic        fwUpdateFail,  // Firmware update failed
	input  wire logic [2:0]  commPhase,     // Communication phase
	input  wire logic [7:0]  busAddr,       // Register byte address
	input  wire logic [31:0] busWrData,     // Write data
	input  wire logic        busWr,         // Write strobe
	input  wire logic        busRd,         // Read strobe
	output logic      [31:0] busRdData,     // Read data, next cycle
	output logic             power_good_indicator, // Green power lamp
	output logic             stGreen,       // Status lamp green
	output logic             stRed,         // Status lamp red
	output logic             fbGreen,       // Fieldbus lamp green
	output logic             fbRed,         // Fieldbus lamp red
	output logic             loopReturn,    // Return on arrival port
	output logic             bootPrevImage, // Run previous firmware
	output logic             restartReq     // One-cycle restart pulse
);

	localparam int NSYNC = 18;
	localparam int TW    = $clog2(TICK_CYCLES + 1);
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
	localparam int PW    = $clog2(PU_BLINKS + 1);
	localparam logic [PW-1:0] PU_LAST = PW'(PU_BLINKS - 1);

	////////////////////////////////////////////////////////////////
	// Pin synchronisation

	logic [NSYNC-1:0] pinRaw;
	logic [NSYNC-1:0] pinSync;
	logic             sSupply;
	logic             sOperable;
	logic             sReady;
	logic             sInit;
	logic             sRecov;
	logic             sCfg;
	logic             sFatal;
	logic             sLink;
	logic             sLoop;
	logic             sDiag;
	logic             sLost;
	logic             sCommErr;
	logic             sRx;
	logic             sDiagMsg;
	logic             sFwFail;
	logic [2:0]       sPhase;

	// Every status level comes from outside this clock domain
	assign pinRaw = {supplyOk, ifOperable, ifReady, ifInit, errRecov,
	                 cfgUnsaved, errFatal, linkUp, loopback, diagErrP1,
	                 commLost, commErr, rxTelegram, diagMsg, fwUpdateFail,
	                 commPhase};

	fsl_sync #(
		.W (NSYNC)
	) u_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.din     (pinRaw),
		.dout    (pinSync)
	);

	// Name the synchronised levels
	assign {sSupply, sOperable, sReady, sInit, sRecov, sCfg, sFatal,
	        sLink, sLoop, sDiag, sLost, sCommErr, sRx, sDiagMsg,
	        sFwFail, sPhase} = pinSync;

	////////////////////////////////////////////////////////////////
	// Shared time base and blink generators

	logic [TW-1:0] tickCnt_q;
	logic          tick_q;
	logic          wInit;
	logic          wRecov;
	logic          wCfg;
	logic          wFatal;
	logic          wFb;

	// Free-running divider; reset restarts every blink in phase
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tickCnt_q <= '0;
			tick_q    <= 1'b0;
		end else if (tickCnt_q == TICK_LAST) begin
			tickCnt_q <= '0;
			tick_q    <= 1'b1;
		end else begin
			tickCnt_q <= tickCnt_q + 1'b1;
			tick_q    <= 1'b0;
		end
	end

	fsl_blink #(.HALF (HALF_INIT)) u_bInit (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.tick    (tick_q),
		.wave    (wInit)
	);

	fsl_blink #(.HALF (HALF_RECOV)) u_bRecov (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.tick    (tick_q),
		.wave    (wRecov)
	);

	fsl_blink #(.HALF (HALF_CFG)) u_bCfg (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.tick    (tick_q),
		.wave    (wCfg)
	);

	fsl_blink #(.HALF (HALF_FATAL)) u_bFatal (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.tick    (tick_q),
		.wave    (wFatal)
	);

	// Loopback, comm error and identify share one 125 ms wave
	fsl_blink #(.HALF (HALF_FB)) u_bFb (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.tick    (tick_q),
		.wave    (wFb)
	);

	////////////////////////////////////////////////////////////////
	// Register port

	logic ident_q;
	logic ackPulse_q;
	logic msgClr_q;
	logic wrCtrl;
	logic [31:0] statusWord;

	assign wrCtrl = busWr && (busAddr == REG_CTRL);

	// Identify level is held; ack and clear are one-cycle pulses
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ident_q    <= 1'b0;
			ackPulse_q <= 1'b0;
			msgClr_q   <= 1'b0;
		end else begin
			ackPulse_q <= wrCtrl && busWrData[CTRL_ACK];
			msgClr_q   <= wrCtrl && busWrData[CTRL_MSGCLR];
			if (wrCtrl) begin
				ident_q <= busWrData[CTRL_IDENT];
			end
		end
	end

	// Read data valid in the cycle after the strobe only
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			busRdData <= RD_IDLE;
		end else if (busRd) begin
			case (busAddr)
				REG_CTRL: begin
					busRdData <= 32'(ident_q) << CTRL_IDENT;
				end
				REG_STATUS: begin
					busRdData <= statusWord;
				end
				default: begin
					busRdData <= RD_IDLE; // Unmapped reads as zero
				end
			endcase
		end else begin
			busRdData <= RD_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////
	// Error latches and phase tracking

	logic [2:0] phasePrev_q;
	logic       cp2to3;
	logic       diagLatch_q;
	logic       commLatch_q;
	logic       msgPend_q;

	// Note the phase one cycle back to see CP2 to CP3
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phasePrev_q <= 3'h0;
		end else begin
			phasePrev_q <= sPhase;
		end
	end

	assign cp2to3 = (phasePrev_q == CP2) && (sPhase == CP3);

	// Ack clears only once the source has gone; a set always wins
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			diagLatch_q <= 1'b0;
		end else if (sDiag || sLost) begin
			diagLatch_q <= 1'b1;
		end else if (ackPulse_q || cp2to3) begin
			diagLatch_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			commLatch_q <= 1'b0;
		end else if (sCommErr) begin
			commLatch_q <= 1'b1;
		end else if (ackPulse_q || cp2to3) begin
			commLatch_q <= 1'b0;
		end
	end

	// Other diagnostics are immune to the error acknowledge
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			msgPend_q <= 1'b0;
		end else if (sDiagMsg) begin
			msgPend_q <= 1'b1;
		end else if (msgClr_q) begin
			msgPend_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Power-up red blinks

	fsl_pu_t       puState_q;
	logic [PW-1:0] puCnt_q;
	logic          wFatalPrev_q;
	logic          fatalFall;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wFatalPrev_q <= 1'b0;
		end else begin
			wFatalPrev_q <= wFatal;
		end
	end

	assign fatalFall = wFatalPrev_q && !wFatal;

	// Count whole red flashes, then hand over to normal display
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			puState_q <= PU_SHOW;
			puCnt_q   <= '0;
		end else begin
			case (puState_q)
				PU_SHOW: begin
					if (fatalFall) begin
						if (puCnt_q == PU_LAST) begin
							puState_q <= PU_RUN;
						end else begin
							puCnt_q <= puCnt_q + 1'b1;
						end
					end
				end
				PU_RUN: begin
					puState_q <= PU_RUN;
				end
				default: begin
					puState_q <= PU_SHOW;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Indicator encoding

	logic stGrnD;
	logic stRedD;
	logic fbGrnD;
	logic fbRedD;

	// Status lamp: darkness first, then power-up blinks, then errors, then phases
	always_comb begin
		stGrnD = 1'b0;
		stRedD = 1'b0;
		if (!sSupply || !sOperable) begin
			stGrnD = 1'b0;
		end else if (puState_q == PU_SHOW) begin
			stRedD = wFatal;
		end else if (sFatal) begin
			stRedD = wFatal;
		end else if (sRecov) begin
			stGrnD = wRecov;
		end else if (sInit) begin
			stGrnD = wInit;
		end else if (sCfg) begin
			stGrnD = wCfg;
		end else if (sReady) begin
			stGrnD = 1'b1;
		end
	end

	// Fieldbus lamp: one pattern, errors ahead of phase and identify
	always_comb begin
		fbGrnD = 1'b0;
		fbRedD = 1'b0;
		if (!sSupply || !sLink) begin
			fbGrnD = 1'b0;
		end else if (diagLatch_q) begin
			fbRedD = 1'b1;
		end else if (commLatch_q) begin
			fbRedD = wFb;
			fbGrnD = !wFb;
		end else if (sLoop) begin
			fbGrnD = wFb;
		end else if (ident_q) begin
			fbGrnD = wFb;
			fbRedD = wFb;
		end else if (sPhase == CP4) begin
			fbGrnD = 1'b1;
		end else if (sPhase <= CP3 && sRx) begin
			fbGrnD = 1'b1;
			fbRedD = 1'b1;
		end
	end

	// Lamp drivers straight from flops
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			power_good_indicator <= 1'b0;
			stGreen              <= 1'b0;
			stRed                <= 1'b0;
			fbGreen              <= 1'b0;
			fbRed                <= 1'b0;
		end else begin
			power_good_indicator <= sSupply;
			stGreen              <= stGrnD;
			stRed                <= stRedD;
			fbGreen              <= fbGrnD;
			fbRed                <= fbRedD;
		end
	end

	////////////////////////////////////////////////////////////////
	// Loop steering and firmware fallback

	logic fwFailPrev_q;

	// Port switch turns each telegram back toward its sender
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			loopReturn <= 1'b0;
		end else begin
			loopReturn <= sLoop && sLink;
		end
	end

	// Fallback sticks until reset so the restart boots the old image
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fwFailPrev_q  <= 1'b0;
			bootPrevImage <= 1'b0;
			restartReq    <= 1'b0;
		end else begin
			fwFailPrev_q <= sFwFail;
			restartReq   <= sFwFail && !fwFailPrev_q;
			if (sFwFail && !fwFailPrev_q) begin
				bootPrevImage <= 1'b1;
			end
		end
	end

	// Status word seen by software
	always_comb begin
		statusWord                        = RD_IDLE;
		statusWord[ST_PWR]                = power_good_indicator;
		statusWord[ST_SGRN]               = stGreen;
		statusWord[ST_SRED]               = stRed;
		statusWord[ST_FGRN]               = fbGreen;
		statusWord[ST_FRED]               = fbRed;
		statusWord[ST_DIAG]               = diagLatch_q;
		statusWord[ST_COMM]               = commLatch_q;
		statusWord[ST_MSG]                = msgPend_q;
		statusWord[ST_PREV]               = bootPrevImage;
		statusWord[ST_PUDONE]             = (puState_q == PU_RUN);
		statusWord[ST_LOOP]               = loopReturn;
		statusWord[ST_PHASE +: 3]         = sPhase;
	end

endmodule

// File: verification/fsl_led_assertions.sv
// Concurrent checks on the status indicator encoder ports
`timescale 1ns/1ps
module fsl_led_assertions (
	input wire logic ref_clk,              // System clock
	input wire logic rst_n,                // Async reset, active low
	input wire logic supplyOk,             // Supply present
	input wire logic ifOperable,           // Interface alive
	input wire logic errFatal,             // Unrecoverable error
	input wire logic linkUp,               // Connection present
	input wire logic loopback,             // Ring broken
	input wire logic diagErrP1,            // Port 1 diag error
	input wire logic power_good_indicator, // Power lamp
	input wire logic stGreen,              // Status green
	input wire logic stRed,                // Status red
	input wire logic fbGreen,              // Fieldbus green
	input wire logic fbRed,                // Fieldbus red
	input wire logic loopReturn,           // Return on arrival port
	input wire logic bootPrevImage,        // Previous image flag
	input wire logic restartReq            // Restart pulse
);
	logic [2:0] upCnt_q;
	logic       upOk;

	// Input history from before reset release says nothing, so wait out the sync depth
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			upCnt_q <= 3'h0;
		end else if (upCnt_q != 3'h4) begin
			upCnt_q <= upCnt_q + 3'h1;
		end
	end
	assign upOk = (upCnt_q == 3'h4);

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	power_lamp_a: assert property (upOk |-> power_good_indicator == $past(supplyOk, 3))
		else $error("power lamp does not follow supply");
	status_dark_a: assert property (upOk && !($past(supplyOk, 3) && $past(ifOperable, 3)) |-> !stGreen && !stRed)
		else $error("status lamp lit without supply");
	bus_dark_a: assert property (upOk && !($past(supplyOk, 3) && $past(linkUp, 3)) |-> !fbGreen && !fbRed)
		else $error("fieldbus lamp lit without link");
	one_colour_a: assert property (!(stGreen && stRed))
		else $error("status lamp shows two colours");
	fatal_red_a: assert property (upOk && $past(errFatal, 3) |-> !stGreen)
		else $error("green shown during fatal error");
	diag_red_a: assert property ((supplyOk && linkUp && diagErrP1) [*6] |-> fbRed && !fbGreen)
		else $error("fieldbus not red on diag error");
	loop_ret_a: assert property (upOk |-> loopReturn == ($past(loopback, 3) && $past(linkUp, 3)))
		else $error("loop return wrong");
	restart_pulse_a: assert property (restartReq |=> !restartReq && bootPrevImage)
		else $error("restart not a single pulse");
	prev_sticky_a: assert property (bootPrevImage |=> bootPrevImage)
		else $error("previous image flag dropped");
endmodule

bind fsl_led_top fsl_led_assertions fsl_led_assertions_i (.ref_clk, .rst_n, .supplyOk, .ifOperable, .errFatal,
	.linkUp, .loopback, .diagErrP1, .power_good_indicator, .stGreen, .stRed, .fbGreen, .fbRed, .loopReturn,
	.bootPrevImage, .restartReq);

// File: verification/fsl_net_model.sv
// Behavioural network master: link, telegram flow and phase stepping
`timescale 1ns/1ps
module fsl_net_model #(
	parameter int GAP = 3
) (
	input  wire logic       ref_clk,    // System clock
	input  wire logic       rst_n,      // Async reset, active low
	input  wire logic       linkCmd,    // Cable plugged
	input  wire logic [2:0] goal,       // Phase to reach
	input  wire logic       crcHit,     // Corrupt telegrams
	output logic            linkUp,     // Connection present
	output logic            rxTelegram, // Telegrams arriving
	output logic      [2:0] commPhase,  // Current phase
	output logic            commErr     // Bad telegram seen
);
	int gapCnt_q;

	// Phases climb one step per gap like a real master; a drop jumps straight down
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			linkUp     <= 1'b0;
			rxTelegram <= 1'b0;
			commErr    <= 1'b0;
			commPhase  <= 3'h0;
			gapCnt_q   <= 0;
		end else begin
			linkUp     <= linkCmd;
			rxTelegram <= linkCmd;
			commErr    <= linkCmd & crcHit;
			gapCnt_q   <= (gapCnt_q == GAP) ? 0 : gapCnt_q + 1;
			if (!linkCmd) begin
				commPhase <= 3'h0;
			end else if (gapCnt_q == GAP && commPhase != goal) begin
				commPhase <= (commPhase < goal) ? commPhase + 3'h1 : goal;
			end
		end
	end
endmodule

// File: verification/testbench.sv
// Self-checking bench for the status indicator encoder
`timescale 1ns/1ps
module testbench
	import fsl_pkg::*;
;
	localparam int TCK = 4;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        supplyOk, ifOperable, ifReady, ifInit, errRecov, cfgUnsaved, errFatal, linkUp, loopback;
	logic        diagErrP1, commLost, commErr, rxTelegram, diagMsg, fwUpdateFail, busWr, busRd, linkCmd, crcHit;
	logic [2:0]  commPhase, goal;
	logic [7:0]  busAddr;
	logic [31:0] busWrData, busRdData, rv;
	logic        power_good_indicator, stGreen, stRed, fbGreen, fbRed, loopReturn, bootPrevImage, restartReq;
	int          err_total, check_count, n;
	int          hs[4] = '{HALF_INIT, HALF_RECOV, HALF_CFG, HALF_FATAL};

	fsl_led_top #(.TICK_CYCLES(TCK), .PU_BLINKS(1)) fsl_led_top_i (.ref_clk, .rst_n, .supplyOk, .ifOperable,
		.ifReady, .ifInit, .errRecov, .cfgUnsaved, .errFatal, .linkUp, .loopback, .diagErrP1, .commLost, .commErr,
		.rxTelegram, .diagMsg, .fwUpdateFail, .commPhase, .busAddr, .busWrData, .busWr, .busRd, .busRdData,
		.power_good_indicator, .stGreen, .stRed, .fbGreen, .fbRed, .loopReturn, .bootPrevImage, .restartReq);
	fsl_net_model #(.GAP(3)) fsl_net_model_i (.ref_clk, .rst_n, .linkCmd, .goal, .crcHit, .linkUp, .rxTelegram,
		.commPhase, .commErr);

	// 25 MHz clock
	always #20 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////////////
	function automatic int expHalf(input int h);
		return h * TCK;
	endfunction
	function automatic logic lamp(input int i);
		case (i)
			0: return stGreen;
			1: return stRed;
			2: return fbGreen;
			default: return fbRed;
		endcase
	endfunction
	task automatic ck(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1) begin
			$display("unexpected %0t %s", $time, m);
			err_total++;
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		busAddr   <= a;
		busWrData <= d;
		busWr     <= 1'b1;
		@(posedge ref_clk);
		busWr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe, zero after that
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		busAddr <= a;
		busRd   <= 1'b1;
		@(posedge ref_clk);
		busRd <= 1'b0;
		@(negedge ref_clk);
		rv = busRdData;
		@(negedge ref_clk);
		ck(busRdData === 32'h0000_0000, "read data lingers");
		@(posedge ref_clk);
	endtask
	task automatic steady(input logic [1:0] e, input int i, input string m);
		logic ok;
		ok = 1'b1;
		cyc(8);
		repeat (2500) begin
			@(negedge ref_clk);
			if ({lamp(i), lamp(i + 1)} !== e) ok = 1'b0;
		end
		ck(ok, m);
		@(posedge ref_clk);
	endtask
	// Measures one lit and one dark phase; bounded so a stuck lamp cannot hang
	task automatic blink(input int i, input int h, input string m);
		int hi, lo, t;
		hi = 0;
		lo = 0;
		t = 0;
		cyc(4); // Let a pattern switched just before the call take effect, else the first phase is cut
		while (lamp(i) !== 1'b0 && t < 30000) begin @(negedge ref_clk); t++; end
		while (lamp(i) !== 1'b1 && t < 30000) begin @(negedge ref_clk); t++; end
		while (lamp(i) === 1'b1 && hi < 30000) begin @(negedge ref_clk); hi++; end
		while (lamp(i) === 1'b0 && lo < 30000) begin @(negedge ref_clk); lo++; end
		ck(hi == expHalf(h) && lo == expHalf(h), m);
		@(posedge ref_clk);
	endtask
	task automatic end_of_test;
		if (err_total == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Watchdog past the expected run length of about 59k cycles
	initial begin
		#(40 * 90000);
		err_total++;
		end_of_test();
	end

	// Main sequence
	initial begin
		{supplyOk, ifOperable, ifReady, ifInit, errRecov, cfgUnsaved, errFatal, loopback, diagErrP1} = '0;
		{commLost, diagMsg, fwUpdateFail, busWr, busRd, linkCmd, crcHit, goal, busAddr, busWrData} = '0;
		err_total = 0;
		check_count = 0;
		void'($urandom(78));
		cyc(2);
		rst_n <= 1'b1;
		cyc(3);
		ck({power_good_indicator, stGreen, stRed, fbGreen, fbRed} === 5'h00, "lamps lit unpowered");
		supplyOk <= 1'b1;
		ifOperable <= 1'b1;
		ifReady <= 1'b1;
		cyc(3000);
		rd(REG_STATUS);
		ck(rv[ST_PUDONE] === 1'b1 && rv[ST_PWR] === 1'b1, "power-up not done");
		steady(2'b10, 0, "status not steady green");
		// Fatal runs with a recoverable error beside it to check precedence
		for (int k = 0; k < 4; k++) begin
			{errFatal, cfgUnsaved, errRecov, ifInit} <= (k == 3) ? 4'hA : 4'h1 << k;
			cyc(8);
			blink(k == 3, hs[k], "status rate");
		end
		{errFatal, cfgUnsaved, errRecov, ifInit} <= 4'h0;
		steady(2'b10, 0, "status stays blinking");
		linkCmd <= 1'b1;
		goal <= CP3;
		cyc(20);
		steady(2'b11, 2, "not orange in early phase");
		goal <= CP4;
		steady(2'b10, 2, "not green in CP4");
		loopback <= 1'b1;
		cyc(8);
		ck(loopReturn === 1'b1, "no loop return");
		blink(2, HALF_FB, "loop rate");
		ck(fbRed === 1'b0, "red during loop");
		loopback <= 1'b0;
		wr(REG_CTRL, 32'h0000_0002);
		blink(3, HALF_FB, "identify rate");
		ck(fbGreen === fbRed, "identify not orange");
		wr(REG_CTRL, 32'h0000_0000);
		crcHit <= 1'b1;
		cyc(6);
		crcHit <= 1'b0;
		blink(3, HALF_FB, "comm error rate");
		ck(fbGreen === ~fbRed, "comm error not alternating");
		diagMsg <= 1'b1;
		wr(REG_CTRL, 32'h0000_0001);
		rd(REG_STATUS);
		ck(rv[ST_COMM] === 1'b0 && rv[ST_MSG] === 1'b1, "ack wrong");
		steady(2'b10, 2, "no green after ack");
		for (int k = 0; k < 2; k++) begin
			{commLost, diagErrP1} <= 2'h1 << k;
			steady(2'b01, 2, "not steady red");
			{commLost, diagErrP1} <= 2'h0;
			cyc(4);
			wr(REG_CTRL, 32'h0000_0001);
			rd(REG_STATUS);
			ck(rv[ST_DIAG] === 1'b0 && rv[ST_MSG] === 1'b1, "diag ack wrong");
		end
		// Pending message needs its own clear
		diagMsg <= 1'b0;
		cyc(4);
		wr(REG_CTRL, 32'h0000_0004);
		rd(REG_STATUS);
		ck(rv[ST_MSG] === 1'b0 && rv[ST_DIAG] === 1'b0, "message not cleared");
		goal <= CP2;
		cyc(8);
		crcHit <= 1'b1;
		cyc(6);
		crcHit <= 1'b0;
		goal <= CP3;
		cyc(12);
		rd(REG_STATUS);
		ck(rv[ST_COMM] === 1'b0 && rv[14:12] === CP3, "phase step kept error");
		rd(8'h08);
		ck(rv === 32'h0000_0000, "unmapped read not zero");
		fwUpdateFail <= 1'b1;
		n = 0;
		repeat (8) begin @(negedge ref_clk); n += restartReq; end
		ck(n == 1 && bootPrevImage === 1'b1, "fallback wrong");
		// Random supply, operable, link and loop levels
		repeat (40) begin
			@(posedge ref_clk);
			{supplyOk, ifOperable, loopback, linkCmd} <= 4'($urandom);
			cyc(6);
			@(negedge ref_clk);
			ck(power_good_indicator === supplyOk && loopReturn === (loopback & linkUp), "random lamp");
		end
		end_of_test();
	end
endmodule
